// >>> hdl/gate_fault_pkg.sv
// Constants shared by the gate driver fault supervision logic.
// Assumes a 10 MHz system clock and 32-bit APB register access.
package gate_fault_pkg;

  localparam int unsigned CLK_MHZ = 10;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // Control register fields
  localparam int CTRL_DRV_EN_BIT    = 0;
  localparam int CTRL_CLEAR_BIT     = 1;
  localparam int CTRL_UV_MODE_BIT   = 2;
  localparam int CTRL_OV_MODE_LSB   = 3;
  localparam int CTRL_OV_LVL_LSB    = 5;
  localparam int CTRL_OV_DG_LSB     = 7;
  localparam int CTRL_PUMP_MODE_BIT = 9;
  localparam int CTRL_PUMP_LVL_LSB  = 10;

  // Status register fields
  localparam int STAT_FAULT_BIT    = 0;
  localparam int STAT_WARN_BIT     = 1;
  localparam int STAT_POR_BIT      = 2;
  localparam int STAT_UV_BIT       = 3;
  localparam int STAT_OV_BIT       = 4;
  localparam int STAT_PUMP_UV_BIT  = 5;
  localparam int STAT_INACTIVE_BIT = 6;
  localparam int STAT_PIN_BIT      = 7;
  localparam int STAT_KILL_BIT     = 8;

  // Recovery select encodings
  localparam logic RECOVER_LATCHED = 1'b0;
  localparam logic RECOVER_AUTO    = 1'b1;

  localparam logic [1:0] OV_LATCHED  = 2'h0;
  localparam logic [1:0] OV_AUTO     = 2'h1;
  localparam logic [1:0] OV_WARN     = 2'h2;
  localparam logic [1:0] OV_DISABLED = 2'h3;

  // Pump threshold code for the two-volt setting
  localparam logic [1:0] PUMP_LVL_2V = 2'h0;

  // Reset values
  localparam logic       DRV_EN_RST    = 1'b0;
  localparam logic       UV_MODE_RST   = RECOVER_LATCHED;
  localparam logic       PUMP_MODE_RST = RECOVER_LATCHED;
  localparam logic [1:0] OV_MODE_RST   = OV_LATCHED;
  localparam logic [1:0] OV_LVL_RST    = 2'h0;
  localparam logic [1:0] OV_DG_RST     = 2'h0;
  localparam logic [1:0] PUMP_LVL_RST  = PUMP_LVL_2V;

  // Deglitch times in microseconds and their cycle counts
  localparam int unsigned POR_DG_US  = 10;
  localparam int unsigned UV_DG_US   = 10;
  localparam int unsigned PUMP_DG_US = 10;
  localparam int unsigned OV_DG0_US  = 1;
  localparam int unsigned OV_DG1_US  = 2;
  localparam int unsigned OV_DG2_US  = 4;
  localparam int unsigned OV_DG3_US  = 8;

  localparam logic [15:0] POR_DG_CYC  = 16'(POR_DG_US * CLK_MHZ);
  localparam logic [15:0] UV_DG_CYC   = 16'(UV_DG_US * CLK_MHZ);
  localparam logic [15:0] PUMP_DG_CYC = 16'(PUMP_DG_US * CLK_MHZ);
  localparam logic [15:0] OV_DG0_CYC  = 16'(OV_DG0_US * CLK_MHZ);
  localparam logic [15:0] OV_DG1_CYC  = 16'(OV_DG1_US * CLK_MHZ);
  localparam logic [15:0] OV_DG2_CYC  = 16'(OV_DG2_US * CLK_MHZ);
  localparam logic [15:0] OV_DG3_CYC  = 16'(OV_DG3_US * CLK_MHZ);

endpackage

// >>> hdl/gate_driver_fault_manager.sv
// Fault supervision and driver enable logic of a gate driver; APB slave.
// Assumes comparators synchronous to clk_sys; host clears once fault is gone.
`timescale 1ns/10ps

module fault_deglitch (
  input  wire logic        clk_sys,   // System clock
  input  wire logic        rst,       // Async reset, active high
  input  wire logic        enable,    // Monitor enabled
  input  wire logic        cmp,       // Raw comparator, condition present
  input  wire logic [15:0] limit,     // Cycles the condition must hold
  output logic             detected   // Qualified condition
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q    <= 16'h0000;
      detected <= 1'b0;
    end else if (!enable || !cmp) begin
      cnt_q    <= 16'h0000;
      detected <= 1'b0;
    end else if (cnt_q + 16'h0001 >= limit) begin
      detected <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  deglitch_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(detected) |-> $past(cmp) && $past(enable))
    else $error("condition qualified without comparator");
  deglitch_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cmp |=> !detected)
    else $error("qualified condition survived comparator drop");
endmodule // fault_deglitch

module gate_driver_fault_manager
  import gate_fault_pkg::*;
#(
  parameter bit PIN_VARIANT = 1'b0 // Fixed-configuration pin variant
) (
  input  wire logic        clk_sys,             // System clock, 10 MHz
  input  wire logic        rst,                 // Async reset, active high
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB access phase
  input  wire logic        pwrite,              // APB write
  input  wire logic [7:0]  paddr,               // APB byte address
  input  wire logic [31:0] pwdata,              // APB write data
  output logic             pready,              // APB ready
  output logic [31:0]      prdata,              // APB read data
  output logic             pslverr,             // APB error
  input  wire logic        driver_kill_pin,     // Hard driver-off input
  input  wire logic        sleep_request_n,     // Low requests sleep
  input  wire logic        logic_supply_low,    // Logic supply below reset
  input  wire logic        supply_uv_cmp,       // Supply below UV level
  input  wire logic        supply_ov_cmp,       // Supply above OV level
  input  wire logic        pump_uv_cmp,         // Pump below UV level
  input  wire logic        fault_alert_out_n_in,  // Alert pin level
  output logic             fault_alert_out_n_out, // Alert pin drive value
  output logic             fault_alert_out_n_oe,  // Alert pin pull-low
  output logic             gate_pulldown_on,    // Gate pulldowns forced
  output logic             gate_drive_enable,   // Gate drivers may switch
  output logic             charge_pump_enable,  // Charge pump running
  output logic             monitors_enable,     // Protection monitors on
  output logic [1:0]       supply_ov_threshold_select, // To OV comparator
  output logic [1:0]       pump_uv_threshold_select    // To pump comparator
);

  // Control register fields
  logic       drv_en_q;
  logic       clear_q;
  logic       uv_mode_q;
  logic [1:0] ov_mode_q;
  logic [1:0] ov_lvl_q;
  logic [1:0] ov_dg_q;
  logic       pump_mode_q;
  logic [1:0] pump_lvl_q;
  // Fault state
  logic       por_flag_q;
  logic       uv_flag_q;
  logic       ov_flag_q;
  logic       pump_flag_q;
  logic       warn_q;
  logic       uv_fault_q;
  logic       ov_fault_q;
  logic       pump_fault_q;
  logic       pump_stop_q;
  logic        wr_ctrl;
  logic        clr;
  logic        inactive;
  logic        supply_reset_det;
  logic        uv_det;
  logic        ov_det;
  logic        pump_det;
  logic        uv_mode;
  logic [1:0]  ov_mode;
  logic        pump_mode;
  logic        drv_allowed;
  logic        summary;
  logic        ov_acts;
  logic [15:0] ov_limit;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  // Pin variant fixes the modes, the enable bit and the pump level; OV level and OV deglitch still follow the register
  assign uv_mode     = PIN_VARIANT ? RECOVER_AUTO : uv_mode_q;
  assign ov_mode     = PIN_VARIANT ? OV_DISABLED : ov_mode_q;
  assign pump_mode   = PIN_VARIANT ? RECOVER_AUTO : pump_mode_q;
  assign drv_allowed = PIN_VARIANT ? 1'b1 : drv_en_q;
  assign supply_ov_threshold_select = ov_lvl_q;
  assign pump_uv_threshold_select = PIN_VARIANT ? PUMP_LVL_2V
                                                : pump_lvl_q;

  // APB slave: no wait states
  assign pready  = 1'b1;
  assign wr_ctrl = psel && penable && pwrite && (paddr == CTRL_OFFSET);
  // Clear is ignored on the pin variant, which has no such bit
  assign clr = clear_q && !PIN_VARIANT;
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_DRV_EN_BIT]    = drv_en_q;
    ctrl_word[CTRL_CLEAR_BIT]     = clear_q;
    ctrl_word[CTRL_UV_MODE_BIT]   = uv_mode_q;
    ctrl_word[CTRL_OV_MODE_LSB+:2] = ov_mode_q;
    ctrl_word[CTRL_OV_LVL_LSB+:2]  = ov_lvl_q;
    ctrl_word[CTRL_OV_DG_LSB+:2]   = ov_dg_q;
    ctrl_word[CTRL_PUMP_MODE_BIT] = pump_mode_q;
    ctrl_word[CTRL_PUMP_LVL_LSB+:2] = pump_lvl_q;
    status_word = 32'h0000_0000;
    status_word[STAT_FAULT_BIT]    = summary;
    status_word[STAT_WARN_BIT]     = warn_q;
    status_word[STAT_POR_BIT]      = por_flag_q;
    status_word[STAT_UV_BIT]       = uv_flag_q;
    status_word[STAT_OV_BIT]       = ov_flag_q;
    status_word[STAT_PUMP_UV_BIT]  = pump_flag_q;
    status_word[STAT_INACTIVE_BIT] = inactive;
    status_word[STAT_PIN_BIT]      = fault_alert_out_n_in;
    status_word[STAT_KILL_BIT]     = driver_kill_pin;
  end

  assign pslverr = psel && penable && !(paddr == CTRL_OFFSET
                   || (paddr == STATUS_OFFSET && !pwrite));
  // Read word taken in the setup cycle so it stands through the access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && paddr == CTRL_OFFSET) begin
      prdata <= ctrl_word;
    end else if (psel && !penable && !pwrite && paddr == STATUS_OFFSET) begin
      prdata <= status_word;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drv_en_q    <= DRV_EN_RST;
      uv_mode_q   <= UV_MODE_RST;
      ov_mode_q   <= OV_MODE_RST;
      ov_lvl_q    <= OV_LVL_RST;
      ov_dg_q     <= OV_DG_RST;
      pump_mode_q <= PUMP_MODE_RST;
      pump_lvl_q  <= PUMP_LVL_RST;
    end else if (wr_ctrl) begin
      drv_en_q    <= pwdata[CTRL_DRV_EN_BIT];
      uv_mode_q   <= pwdata[CTRL_UV_MODE_BIT];
      ov_mode_q   <= pwdata[CTRL_OV_MODE_LSB+:2];
      ov_lvl_q    <= pwdata[CTRL_OV_LVL_LSB+:2];
      ov_dg_q     <= pwdata[CTRL_OV_DG_LSB+:2];
      pump_mode_q <= pwdata[CTRL_PUMP_MODE_BIT];
      pump_lvl_q  <= pwdata[CTRL_PUMP_LVL_LSB+:2];
    end
  end

  // Clear bit stands for one cycle, then drops by itself
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= wr_ctrl && pwdata[CTRL_CLEAR_BIT];
    end
  end

  // Monitors and qualifiers
  fault_deglitch u_por_dg (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .enable   (1'b1),
    .cmp      (logic_supply_low),
    .limit    (POR_DG_CYC),
    .detected (supply_reset_det)
  );

  assign inactive = supply_reset_det || !sleep_request_n;
  always_comb begin
    case (ov_dg_q)
      2'h0:    ov_limit = OV_DG0_CYC;
      2'h1:    ov_limit = OV_DG1_CYC;
      2'h2:    ov_limit = OV_DG2_CYC;
      default: ov_limit = OV_DG3_CYC;
    endcase
  end

  fault_deglitch u_uv_dg (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .enable   (!inactive),
    .cmp      (supply_uv_cmp),
    .limit    (UV_DG_CYC),
    .detected (uv_det)
  );

  fault_deglitch u_ov_dg (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .enable   (!inactive && ov_mode != OV_DISABLED),
    .cmp      (supply_ov_cmp),
    .limit    (ov_limit),
    .detected (ov_det)
  );

  fault_deglitch u_pump_dg (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .enable   (!inactive),
    .cmp      (pump_uv_cmp),
    .limit    (PUMP_DG_CYC),
    .detected (pump_det)
  );

  assign ov_acts = (ov_mode == OV_LATCHED) || (ov_mode == OV_AUTO);
  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_flag_q <= 1'b1;
    end else begin
      por_flag_q <= supply_reset_det || (por_flag_q && !clr);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      uv_flag_q   <= 1'b0;
      ov_flag_q   <= 1'b0;
      pump_flag_q <= 1'b0;
      warn_q      <= 1'b0;
    end else begin
      uv_flag_q   <= uv_det || (uv_flag_q && !clr);
      ov_flag_q   <= (ov_det && ov_mode != OV_DISABLED)
                     || (ov_flag_q && !clr);
      pump_flag_q <= pump_det || (pump_flag_q && !clr);
      warn_q <= (ov_det && ov_mode == OV_WARN) || (warn_q && !clr);
    end
  end

  // Fault state: held only in latched mode; in auto mode faults follow detection, pump stop never sets
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      uv_fault_q   <= 1'b0;
      ov_fault_q   <= 1'b0;
      pump_fault_q <= 1'b0;
      pump_stop_q  <= 1'b0;
    end else begin
      uv_fault_q <= uv_det || (uv_fault_q && !clr
                    && uv_mode == RECOVER_LATCHED);
      ov_fault_q <= (ov_det && ov_acts) || (ov_fault_q && !clr
                    && ov_mode == OV_LATCHED);
      pump_fault_q <= pump_det || (pump_fault_q && !clr
                      && pump_mode == RECOVER_LATCHED);
      pump_stop_q <= (pump_det && pump_mode == RECOVER_LATCHED)
                     || (pump_stop_q && !clr
                     && pump_mode == RECOVER_LATCHED);
    end
  end
  assign summary = uv_fault_q || ov_fault_q || pump_fault_q;

  // Output stage from flops; kill pin takes effect one cycle later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gate_pulldown_on      <= 1'b1;
      gate_drive_enable     <= 1'b0;
      charge_pump_enable    <= 1'b0;
      monitors_enable       <= 1'b0;
      fault_alert_out_n_oe  <= 1'b0;
      fault_alert_out_n_out <= 1'b0;
    end else begin
      gate_pulldown_on  <= driver_kill_pin || inactive || !drv_allowed
                           || summary;
      gate_drive_enable <= !(driver_kill_pin || inactive || !drv_allowed
                           || summary);
      charge_pump_enable <= !(inactive || uv_fault_q
                           || pump_stop_q);
      monitors_enable   <= !inactive;
      fault_alert_out_n_oe  <= summary;
      fault_alert_out_n_out <= 1'b0;
    end
  end

  kill_pulldown_a: assert property (@(posedge clk_sys) disable iff (rst)
    driver_kill_pin |=> gate_pulldown_on && !gate_drive_enable)
    else $error("kill pin did not force pulldowns");
  enable_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    !PIN_VARIANT && !drv_en_q |=> gate_pulldown_on)
    else $error("drivers enabled without enable bit");
  pin_auto_en_a: assert property (@(posedge clk_sys) disable iff (rst)
    PIN_VARIANT && !driver_kill_pin && !inactive && !summary
    |=> gate_drive_enable)
    else $error("pin variant drivers not enabled");
  clear_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    clear_q |=> !clear_q)
    else $error("clear bit did not self-clear");
  inactive_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    inactive |=> !charge_pump_enable && !monitors_enable
    && gate_pulldown_on)
    else $error("inactive state left outputs on");
  por_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    por_flag_q && !clr |=> por_flag_q)
    else $error("reset status bit lost without clear");
  uv_response_a: assert property (@(posedge clk_sys) disable iff (rst)
    uv_det |=> uv_flag_q ##1 (fault_alert_out_n_oe
    && !charge_pump_enable))
    else $error("supply undervoltage response missing");
  uv_latched_a: assert property (@(posedge clk_sys) disable iff (rst)
    uv_fault_q && uv_mode == RECOVER_LATCHED && !clr |=> uv_fault_q)
    else $error("latched undervoltage fault dropped");
  uv_auto_a: assert property (@(posedge clk_sys) disable iff (rst)
    uv_mode == RECOVER_AUTO && !uv_det |=> !uv_fault_q)
    else $error("auto undervoltage did not recover");
  ov_warn_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    ov_mode == OV_WARN |=> !ov_fault_q)
    else $error("warning mode took driver action");
  ov_silent_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(ov_flag_q) |-> $past(ov_mode) != OV_DISABLED)
    else $error("disabled overvoltage reported");
  pump_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    pump_det && pump_mode == RECOVER_LATCHED |=> ##1
    !charge_pump_enable)
    else $error("latched pump fault left pump running");
  pump_auto_a: assert property (@(posedge clk_sys) disable iff (rst)
    pump_mode == RECOVER_AUTO |=> !pump_stop_q)
    else $error("auto pump mode stopped pump");

endmodule // gate_driver_fault_manager

// >>> sim/host_mcu_model.sv
// Host controller model: APB master tasks and the alert wire pull-up.
// Assumes an APB slave clocked by clk_sys.
`timescale 1ns/10ps

module host_mcu_model (
  input  wire logic        clk_sys,    // System clock
  output logic             psel,       // APB select
  output logic             penable,    // APB access phase
  output logic             pwrite,     // APB write
  output logic [7:0]       paddr,      // APB byte address
  output logic [31:0]      pwdata,     // APB write data
  input  wire logic        pready,     // APB ready
  input  wire logic [31:0] prdata,     // APB read data
  input  wire logic        pslverr,    // APB error
  input  wire logic        alert_oe,   // Device pulls alert low
  output logic             alert_level // Alert wire with pull-up
);
  assign alert_level = ~alert_oe;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Callers hold a clear back until the fault input is gone
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for ready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // host_mcu_model

// >>> sim/test_gate_driver_fault_manager.sv
// Self-checking bench for the gate driver fault manager.
// Assumes the host model as APB master; a pin-variant twin shares inputs.
`timescale 1ns/10ps

module test_gate_driver_fault_manager;
  import gate_fault_pkg::*;

  typedef struct packed {
    logic [2:0]  src;  // Comparators {pump, ov, uv}
    logic [31:0] ctrl;
    logic [2:0]  out1; // {alert oe, pulldown, pump} with fault present
    logic [8:0]  st1;
    logic [2:0]  out2; // Same after the fault input drops
    logic [8:0]  st2;
  } row_s;

  localparam row_s ROWS [8] = '{
    '{3'h1, 32'h1,   3'h6, 9'h009, 3'h6, 9'h009},
    '{3'h1, 32'h5,   3'h6, 9'h009, 3'h1, 9'h088},
    '{3'h2, 32'h81,  3'h7, 9'h011, 3'h7, 9'h011},
    '{3'h2, 32'h109, 3'h7, 9'h011, 3'h1, 9'h090},
    '{3'h2, 32'h11,  3'h1, 9'h092, 3'h1, 9'h092},
    '{3'h2, 32'h19,  3'h1, 9'h080, 3'h1, 9'h080},
    '{3'h4, 32'h1,   3'h6, 9'h021, 3'h6, 9'h021},
    '{3'h4, 32'h201, 3'h7, 9'h021, 3'h1, 9'h0A0}};
  localparam int LIMIT = 20000;
  localparam int HOLD  = int'(UV_DG_CYC) + 10;

  logic        clk_sys, rst, driver_kill_pin, sleep_request_n;
  logic        logic_supply_low, psel, penable, pwrite, pready, pslverr;
  logic        alert_lvl, oe, pd, ge, cp, me, poe, ppd, pge, e, ao;
  logic [2:0]  cmp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  ovsel, pusel, ppusel;
  int          err_total, checked, cycles;

  gate_driver_fault_manager #(.PIN_VARIANT(1'b0)) dut (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .driver_kill_pin, .sleep_request_n,
    .logic_supply_low, .supply_uv_cmp(cmp[0]), .supply_ov_cmp(cmp[1]),
    .pump_uv_cmp(cmp[2]), .fault_alert_out_n_in(alert_lvl),
    .fault_alert_out_n_out(ao), .fault_alert_out_n_oe(oe),
    .gate_pulldown_on(pd), .gate_drive_enable(ge),
    .charge_pump_enable(cp), .monitors_enable(me),
    .supply_ov_threshold_select(ovsel), .pump_uv_threshold_select(pusel));

  gate_driver_fault_manager #(.PIN_VARIANT(1'b1)) dut_pin (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready(), .prdata(), .pslverr(), .driver_kill_pin, .sleep_request_n,
    .logic_supply_low, .supply_uv_cmp(cmp[0]), .supply_ov_cmp(cmp[1]),
    .pump_uv_cmp(cmp[2]), .fault_alert_out_n_in(~poe),
    .fault_alert_out_n_out(), .fault_alert_out_n_oe(poe),
    .gate_pulldown_on(ppd), .gate_drive_enable(pge),
    .charge_pump_enable(), .monitors_enable(),
    .supply_ov_threshold_select(), .pump_uv_threshold_select(ppusel));

  host_mcu_model host (
    .clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .alert_oe(oe), .alert_level(alert_lvl));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard; whole run needs well under this
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [31:0] d);
    host.xfer(1'b1, CTRL_OFFSET, d, rd, e);
  endtask

  task automatic stat(input logic [31:0] x, input string nm);
    host.xfer(1'b0, STATUS_OFFSET, 32'h0, rd, e);
    check(nm, rd, x);
  endtask

  task automatic outs(input logic [2:0] x, input string nm);
    check(nm, 32'({oe, pd, cp}), 32'(x));
  endtask

  // Used at start and again at the end of the run, so reset is seen twice
  task automatic reset_dut();
    rst <= 1'b1;
    cyc(16);
    rst <= 1'b0;
    cyc(3);
    check("drive_en", 32'({ge, pd}), 32'h1);
    check("pin_drive_en", 32'(pge), 32'h1);
    stat(32'h84, "status_rst");
    wr(32'h1);
    cyc(3);
    check("drive_en_set", 32'({ge, pd}), 32'h2);
    wr(32'h3);
    host.xfer(1'b0, CTRL_OFFSET, 32'h0, rd, e);
    check("clear_self", rd, 32'h1);
    stat(32'h80, "status_clr");
  endtask

  initial begin
    rst = 1'b1;
    driver_kill_pin = 1'b0;
    sleep_request_n = 1'b1;
    logic_supply_low = 1'b0;
    cmp = 3'h0;
    err_total = 0;
    checked = 0;
    cycles = 0;
    reset_dut();
    foreach (ROWS[i]) begin
      wr(ROWS[i].ctrl);
      cmp <= ROWS[i].src;
      cyc(HOLD);
      outs(ROWS[i].out1, "outs_on");
      check("alert_out", 32'(ao), 32'h0);
      check("pin_on", 32'(poe), 32'(ROWS[i].src[0] | ROWS[i].src[2]));
      stat({23'h0, ROWS[i].st1}, "stat_on");
      cmp <= 3'h0;
      cyc(10);
      outs(ROWS[i].out2, "outs_off");
      check("pin_off", 32'(poe), 32'h0);
      stat({23'h0, ROWS[i].st2}, "stat_off");
      wr(ROWS[i].ctrl | 32'h2);
      cyc(5);
      outs(3'h1, "outs_clr");
      stat(32'h80, "stat_clr");
    end
    driver_kill_pin <= 1'b1;
    cyc(3);
    check("kill", 32'({pd, ge, ppd}), 32'h5);
    stat(32'h180, "stat_kill");
    driver_kill_pin <= 1'b0;
    cyc(3);
    check("kill_off", 32'({pd, ge}), 32'h1);
    // Two near-misses of the deglitch count must not add up
    cmp <= 3'h1;
    cyc(HOLD - 20);
    cmp <= 3'h0;
    cyc(1);
    cmp <= 3'h1;
    cyc(HOLD - 20);
    cmp <= 3'h0;
    cyc(3);
    outs(3'h1, "dg_restart");
    stat(32'h80, "stat_dg");
    wr(32'h181);
    cmp <= 3'h2;
    cyc(int'(OV_DG3_CYC) - 5);
    outs(3'h1, "ov_dg_short");
    cyc(10);
    outs(3'h7, "ov_dg_long");
    cmp <= 3'h0;
    wr(32'h183);
    wr(32'h861);
    host.xfer(1'b0, CTRL_OFFSET, 32'h0, rd, e);
    check("ctrl_rd", rd, 32'h861);
    check("sel_out", 32'({ovsel, pusel, ppusel}), 32'h38);
    host.xfer(1'b1, STATUS_OFFSET, 32'h1FF, rd, e);
    check("ro_err", 32'(e), 32'h1);
    host.xfer(1'b0, 8'h08, 32'h0, rd, e);
    check("unmapped", {rd[30:0], e}, 32'h1);
    stat(32'h80, "stat_kept");
    sleep_request_n <= 1'b0;
    cyc(3);
    check("sleep", 32'({me, cp, ge}), 32'h0);
    stat(32'hC0, "stat_sleep");
    sleep_request_n <= 1'b1;
    cyc(3);
    check("wake", 32'({me, cp, ge}), 32'h7);
    logic_supply_low <= 1'b1;
    cyc(HOLD);
    check("supply_low", 32'(me), 32'h0);
    logic_supply_low <= 1'b0;
    cyc(5);
    check("supply_back", 32'(me), 32'h1);
    stat(32'h84, "stat_por");
    reset_dut();
    tally_and_finish();
  end
endmodule // test_gate_driver_fault_manager
